// ==== logic/ring_opt_pkg.sv ====
// ring_opt_pkg: option word layout, register offsets and shared types
// assumes: used by ring_network_option_bits and its response mux
package ring_opt_pkg;

  // register byte offsets (word aligned)
  localparam logic [3:0] OFF_OPTION     = 4'h0;
  localparam logic [3:0] OFF_STATUS     = 4'h4;
  localparam logic [3:0] OFF_NET_ENABLE = 4'h8;

  // option word field positions
  localparam int BIT_POS_SHIFT  = 0;
  localparam int BIT_START_HOLD = 1;
  localparam int BIT_HOME_SRC   = 2;
  localparam int BIT_LOOP_SYNC  = 3;
  localparam int AUX_SEL_LO     = 4;
  localparam int AUX_SEL_W      = 4;
  localparam int OPT_W          = 16;

  // position data shift when compatibility bit is set
  localparam int POS_SHIFT_BITS = 5;

  localparam logic [15:0] OPTION_RESET = 16'h0000;

  // auxiliary register selector codes
  localparam logic [3:0] AUX_DIGITAL_IN = 4'h0;
  localparam logic [3:0] AUX_MOTOR_ENC  = 4'h3;
  localparam logic [3:0] AUX_LOAD_ENC   = 4'h4;

  // status register bit positions
  localparam int ST_DRIVE_EN  = 0;
  localparam int ST_NET_SEEN  = 1;
  localparam int ST_HOME      = 2;
  localparam int ST_LOOP_SYNC = 3;

  typedef struct packed {
    logic [31:0] motor_enc;
    logic [31:0] load_enc;
    logic [31:0] digital_in;
  } aux_src_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [3:0]  address;
    logic [31:0] writedata;
  } avmm_req_t;

  typedef enum logic [1:0] {
    ENA_STARTUP,
    ENA_RUN,
    ENA_HOLD
  } ena_state_t;

endpackage : ring_opt_pkg

// ==== logic/ring_aux_select.sv ====
// ring_aux_select: picks the first auxiliary response word from the selector code
// assumes: sources are synchronous to clk_in; registered output
`timescale 1ns/1ps
`default_nettype none
module ring_aux_select (
  input  wire logic                  clk_in,
  input  wire logic                  resetn_in,
  input  wire logic [3:0]            sel_in,
  input  wire ring_opt_pkg::aux_src_t src_in,
  output logic [31:0]                aux_out
);

  logic [31:0] aux_ff;
  logic [31:0] nxt_aux;

  always_comb begin
    case (sel_in)
      ring_opt_pkg::AUX_DIGITAL_IN: nxt_aux = src_in.digital_in;
      ring_opt_pkg::AUX_MOTOR_ENC:  nxt_aux = src_in.motor_enc;
      ring_opt_pkg::AUX_LOAD_ENC:   nxt_aux = src_in.load_enc;
      default:                      nxt_aux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aux_ff <= 32'h0000_0000;
    end else begin
      aux_ff <= nxt_aux;
    end
  end

  assign aux_out = aux_ff;

endmodule // ring_aux_select
`default_nettype wire

// ==== logic/ring_network_option_bits.sv ====
// ring_network_option_bits: option word of a servo drive on a ring motion network
// assumes: Avalon-MM slave on clk_in; network inputs synchronous to clk_in
//
// Functional notes
// - bit0 shifts sent position up five
// - bit1 holds drive off until network enable
// - bit1 clear runs drive until messages arrive
// - bit2 picks encoder index for home status
// - bit3 requests current loop lock to ring
// - bits4-7 select first auxiliary register content
// - codes 0 digital, 3 motor, 4 load
`timescale 1ns/1ps
`default_nettype none
module ring_network_option_bits #(
  parameter int POS_W = 32
) (
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  // avalon-mm slave
  input  wire logic [3:0]             avs_address_in,
  input  wire logic                   avs_read_in,
  input  wire logic                   avs_write_in,
  input  wire logic [31:0]            avs_writedata_in,
  input  wire logic [3:0]             avs_byteenable_in,
  output logic [31:0]                 avs_readdata_out,
  output logic                        avs_waitrequest_out,
  output logic                        avs_response_err_out,
  // network side
  input  wire logic                   net_msg_valid_in,
  input  wire logic                   net_enable_cmd_in,
  input  wire logic                   net_disable_cmd_in,
  input  wire logic [POS_W-1:0]       position_in,
  input  wire logic                   enc_index_in,
  input  wire logic                   gp_home_in,
  input  wire ring_opt_pkg::aux_src_t aux_src_in,
  // drive side
  output logic [POS_W-1:0]            tx_position_out,
  output logic                        tx_home_out,
  output logic [31:0]                 tx_aux1_out,
  output logic                        drive_enable_out,
  output logic                        loop_sync_req_out
);

  logic [15:0]                    option_ff;
  logic                           ack_ff;
  logic [31:0]                    rdata_ff;
  logic                           err_ff;
  logic                           sw_enable_ff;
  logic                           net_seen_ff;
  ring_opt_pkg::ena_state_t       ena_state_ff;
  ring_opt_pkg::ena_state_t       nxt_ena_state;
  logic [POS_W-1:0]               tx_pos_ff;
  logic                           tx_home_ff;
  logic                           drive_en_ff;
  logic                           loop_sync_ff;
  logic                           hit;
  logic                           wr_take;
  logic                           rd_take;
  logic [31:0]                    status_word;

  function automatic logic addr_mapped(input logic [3:0] a);
    addr_mapped = (a == ring_opt_pkg::OFF_OPTION) ||
                  (a == ring_opt_pkg::OFF_STATUS) ||
                  (a == ring_opt_pkg::OFF_NET_ENABLE);
  endfunction

  // one wait cycle per access: request is taken on the edge where waitrequest is low
  assign hit     = (avs_read_in || avs_write_in) && !ack_ff;
  assign wr_take = avs_write_in && ack_ff;
  assign rd_take = avs_read_in && ack_ff;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= hit;
    end
  end

  // option word, byte lanes 0 and 1
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      option_ff <= ring_opt_pkg::OPTION_RESET;
    end else if (wr_take && avs_address_in == ring_opt_pkg::OFF_OPTION) begin
      if (avs_byteenable_in[0]) begin
        option_ff[7:0] <= avs_writedata_in[7:0];
      end
      if (avs_byteenable_in[1]) begin
        option_ff[15:8] <= avs_writedata_in[15:8];
      end
    end
  end

  // software stand-in for the network enable command; bit0 gives a one-cycle enable pulse, write 0 has no effect
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sw_enable_ff <= 1'b0;
    end else if (wr_take && avs_address_in == ring_opt_pkg::OFF_NET_ENABLE
                 && avs_byteenable_in[0]) begin
      sw_enable_ff <= avs_writedata_in[0];
    end else if (sw_enable_ff) begin
      sw_enable_ff <= 1'b0;
    end
  end

  // sticky: first network message ends stand-alone operation
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      net_seen_ff <= 1'b0;
    end else if (net_msg_valid_in) begin
      net_seen_ff <= 1'b1;
    end
  end

  always_comb begin
    status_word                            = 32'h0000_0000;
    status_word[ring_opt_pkg::ST_DRIVE_EN]  = drive_en_ff;
    status_word[ring_opt_pkg::ST_NET_SEEN]  = net_seen_ff;
    status_word[ring_opt_pkg::ST_HOME]      = tx_home_ff;
    status_word[ring_opt_pkg::ST_LOOP_SYNC] = loop_sync_ff;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rdata_ff <= 32'h0000_0000;
      err_ff   <= 1'b0;
    end else if (hit) begin
      err_ff <= !addr_mapped(avs_address_in);
      if (avs_read_in) begin
        case (avs_address_in)
          ring_opt_pkg::OFF_OPTION: rdata_ff <= {16'h0000, option_ff};
          ring_opt_pkg::OFF_STATUS: rdata_ff <= status_word;
          default:                  rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  // startup enable policy
  always_comb begin
    nxt_ena_state = ena_state_ff;
    case (ena_state_ff)
      ring_opt_pkg::ENA_STARTUP: begin
        if (option_ff[ring_opt_pkg::BIT_START_HOLD]) begin
          nxt_ena_state = ring_opt_pkg::ENA_HOLD;
        end else if (net_msg_valid_in) begin
          // network now owns enable; wait for its command
          nxt_ena_state = ring_opt_pkg::ENA_HOLD;
        end
      end
      ring_opt_pkg::ENA_HOLD: begin
        if ((net_enable_cmd_in || sw_enable_ff) && !net_disable_cmd_in) begin
          nxt_ena_state = ring_opt_pkg::ENA_RUN;
        end
      end
      ring_opt_pkg::ENA_RUN: begin
        if (net_disable_cmd_in) begin
          nxt_ena_state = ring_opt_pkg::ENA_HOLD;
        end
      end
      default: nxt_ena_state = ring_opt_pkg::ENA_STARTUP;
    endcase
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ena_state_ff <= ring_opt_pkg::ENA_STARTUP;
    end else begin
      ena_state_ff <= nxt_ena_state;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      drive_en_ff <= 1'b0;
    end else begin
      // stand-alone operation only while no hold is requested and no message seen
      drive_en_ff <= (nxt_ena_state == ring_opt_pkg::ENA_RUN) ||
                     (nxt_ena_state == ring_opt_pkg::ENA_STARTUP &&
                      !option_ff[ring_opt_pkg::BIT_START_HOLD]);
    end
  end

  // outgoing position, optional shift for controller compatibility
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_pos_ff <= '0;
    end else if (option_ff[ring_opt_pkg::BIT_POS_SHIFT]) begin
      tx_pos_ff <= position_in << ring_opt_pkg::POS_SHIFT_BITS;
    end else begin
      tx_pos_ff <= position_in;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_home_ff <= 1'b0;
    end else begin
      tx_home_ff <= option_ff[ring_opt_pkg::BIT_HOME_SRC] ? enc_index_in
                                                           : gp_home_in;
    end
  end

  // request only; the loop timer must see a ring period that divides evenly
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      loop_sync_ff <= 1'b0;
    end else begin
      loop_sync_ff <= option_ff[ring_opt_pkg::BIT_LOOP_SYNC];
    end
  end

  ring_aux_select u_aux (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .sel_in    (option_ff[ring_opt_pkg::AUX_SEL_LO +: ring_opt_pkg::AUX_SEL_W]),
    .src_in    (aux_src_in),
    .aux_out   (tx_aux1_out)
  );

  assign avs_readdata_out     = rdata_ff;
  assign avs_waitrequest_out  = !ack_ff;
  assign avs_response_err_out = err_ff;
  assign tx_position_out      = tx_pos_ff;
  assign tx_home_out          = tx_home_ff;
  assign drive_enable_out     = drive_en_ff;
  assign loop_sync_req_out    = loop_sync_ff;

endmodule // ring_network_option_bits
`default_nettype wire

// ==== tb/ring_opt_props.sv ====
// ring_opt_props: port-level checker for the option word effects
// assumes: bound to ring_network_option_bits; one clock, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module ring_opt_props #(parameter int POS_W = 32) (
  input wire logic                   clk_in,
  input wire logic                   resetn_in,
  input wire logic [3:0]             avs_address_in,
  input wire logic                   avs_write_in,
  input wire logic [31:0]            avs_writedata_in,
  input wire logic                   avs_waitrequest_out,
  input wire logic                   net_msg_valid_in,
  input wire logic                   net_enable_cmd_in,
  input wire logic                   net_disable_cmd_in,
  input wire logic [POS_W-1:0]       position_in,
  input wire logic                   enc_index_in,
  input wire logic                   gp_home_in,
  input wire ring_opt_pkg::aux_src_t aux_src_in,
  input wire logic [POS_W-1:0]       tx_position_out,
  input wire logic                   tx_home_out,
  input wire logic [31:0]            tx_aux1_out,
  input wire logic                   drive_enable_out,
  input wire logic                   loop_sync_req_out
);
  logic [7:0] opt_ff;
  logic       seen_ff;
  logic [1:0] age_ff;
  logic       wr_ok;
  logic       en_wr;
  assign wr_ok = avs_write_in && !avs_waitrequest_out;
  assign en_wr = wr_ok && avs_address_in == 4'h8 && avs_writedata_in[0];
  // mirror of the low option byte, updated at the same edge as the block's own copy
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) opt_ff <= 8'h00;
    else if (wr_ok && avs_address_in == 4'h0) opt_ff <= avs_writedata_in[7:0];
  end
  // seen_ff latches anything that may legally end the startup run
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      seen_ff <= 1'b0;
      age_ff  <= 2'h0;
    end else begin
      seen_ff <= seen_ff | net_msg_valid_in | net_disable_cmd_in | opt_ff[1];
      age_ff  <= age_ff + {1'b0, age_ff != 2'h3};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_no_enable;
    (!net_enable_cmd_in && !en_wr) [*3];
  endsequence
  property p_hold_off;
    s_no_enable ##0 (opt_ff[1] && !drive_enable_out) |=> !drive_enable_out;
  endproperty
  property p_startup_run;
    age_ff == 2'h3 && !seen_ff |-> drive_enable_out;
  endproperty
  property p_pos_shift;
    $past(resetn_in) |-> tx_position_out ==
      ($past(opt_ff[0]) ? $past(position_in) << 5 : $past(position_in));
  endproperty
  property p_home_src;
    $past(resetn_in) |-> tx_home_out == ($past(opt_ff[2]) ? $past(enc_index_in) : $past(gp_home_in));
  endproperty
  property p_loop_sync;
    $past(resetn_in) |-> loop_sync_req_out == $past(opt_ff[3]);
  endproperty
  property p_aux_digital;
    $past(resetn_in) && $past(opt_ff[7:4]) == 4'h0 |-> tx_aux1_out == $past(aux_src_in.digital_in);
  endproperty
  property p_aux_enc;
    $past(resetn_in) && $past(opt_ff[7:4]) inside {4'h3, 4'h4} |-> tx_aux1_out ==
      ($past(opt_ff[4]) ? $past(aux_src_in.motor_enc) : $past(aux_src_in.load_enc));
  endproperty
  property p_aux_rsvd;
    $past(resetn_in) && !($past(opt_ff[7:4]) inside {4'h0, 4'h3, 4'h4}) |-> tx_aux1_out == 32'h0;
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("drive enabled without enable");
  a_startup_run: assert property (p_startup_run) else $error("startup drive off");
  a_pos_shift: assert property (p_pos_shift) else $error("position shift wrong");
  a_home_src: assert property (p_home_src) else $error("home source wrong");
  a_loop_sync: assert property (p_loop_sync) else $error("loop sync request wrong");
  a_aux_digital: assert property (p_aux_digital) else $error("aux digital wrong");
  a_aux_enc: assert property (p_aux_enc) else $error("aux encoder wrong");
  a_aux_rsvd: assert property (p_aux_rsvd) else $error("aux reserved not zero");
endmodule // ring_opt_props
bind ring_network_option_bits ring_opt_props #(.POS_W(POS_W)) u_props (.clk_in, .resetn_in,
  .avs_address_in, .avs_write_in, .avs_writedata_in, .avs_waitrequest_out, .net_msg_valid_in,
  .net_enable_cmd_in, .net_disable_cmd_in, .position_in, .enc_index_in, .gp_home_in,
  .aux_src_in, .tx_position_out, .tx_home_out, .tx_aux1_out, .drive_enable_out,
  .loop_sync_req_out);
`default_nettype wire

// ==== tb/ring_ctl_model.sv ====
// ring_ctl_model: behavioural ring controller issuing messages and commands
// assumes: the bench calls send; outputs change just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ring_ctl_model (
  input  wire logic clk_in,
  output logic      net_msg_valid_out,
  output logic      net_enable_cmd_out,
  output logic      net_disable_cmd_out
);
  localparam int PWM_PER  = 4;
  localparam int RING_PER = 3 * PWM_PER;
  initial begin
    net_msg_valid_out   = 1'b0;
    net_enable_cmd_out  = 1'b0;
    net_disable_cmd_out = 1'b0;
  end
  // kind 0 message, 1 enable, 2 disable; hold stretches it for a slow controller
  task automatic send(input int kind, input int hold);
    @(posedge clk_in);
    net_msg_valid_out   <= kind == 0;
    net_enable_cmd_out  <= kind == 1;
    net_disable_cmd_out <= kind == 2;
    repeat (hold) @(posedge clk_in);
    net_msg_valid_out   <= 1'b0;
    net_enable_cmd_out  <= 1'b0;
    net_disable_cmd_out <= 1'b0;
    repeat (RING_PER) @(posedge clk_in);
  endtask
endmodule // ring_ctl_model
`default_nettype wire

// ==== tb/test_ring_network_option_bits.sv ====
// test_ring_network_option_bits: directed bench for the option word block
// assumes: ring_ctl_model stands in for the network controller
`timescale 1ns/1ps
`default_nettype none
module test_ring_network_option_bits;
  logic        clk_in = 1'b0, resetn_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
  logic [3:0]  avs_address_in = 4'h0;
  logic [31:0] avs_writedata_in = 32'h0, position_in = 32'h0, q, avs_readdata_out;
  logic [31:0] tx_position_out, tx_aux1_out;
  logic        avs_waitrequest_out, avs_response_err_out, e, enc_index_in = 1'b0;
  logic        gp_home_in = 1'b0, tx_home_out, drive_enable_out, loop_sync_req_out;
  logic        net_msg_valid_in, net_enable_cmd_in, net_disable_cmd_in;
  ring_opt_pkg::aux_src_t aux_src_in = {32'h1111_1111, 32'h2222_2222, 32'h3333_3333};
  int          n_mismatch = 0, total_checks = 0;
  always #5 clk_in = ~clk_in;
  ring_network_option_bits #(.POS_W(32)) uut (.clk_in, .resetn_in, .avs_address_in,
    .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in(4'hf),
    .avs_readdata_out, .avs_waitrequest_out, .avs_response_err_out, .net_msg_valid_in,
    .net_enable_cmd_in, .net_disable_cmd_in, .position_in, .enc_index_in, .gp_home_in,
    .aux_src_in, .tx_position_out, .tx_home_out, .tx_aux1_out, .drive_enable_out,
    .loop_sync_req_out);
  ring_ctl_model u_ctl (.clk_in, .net_msg_valid_out(net_msg_valid_in),
    .net_enable_cmd_out(net_enable_cmd_in), .net_disable_cmd_out(net_disable_cmd_in));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one bus access; the extra edge keeps release and the next request apart
  // only the watchdog ends a wait that never sees waitrequest low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= w;
    avs_read_in      <= !w;
    do begin
      @(posedge clk_in);
    end while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    e = avs_response_err_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic t_start;
    tick(3);
    chk(32'(drive_enable_out), 32'h1);
    bus(0, 4'hc, 32'h0);
    chk(q, 32'h0);
    chk(32'(e), 32'h1);
    u_ctl.send(0, 1);
    chk(32'(drive_enable_out), 32'h0);
    bus(0, 4'h4, 32'h0);
    chk(q, 32'h0000_0002);
    u_ctl.send(1, 1);
    chk(32'(drive_enable_out), 32'h1);
    $display("t_start done");
  endtask
  task automatic t_hold;
    // the hold bit only acts from startup, so begin again from reset
    resetn_in <= 1'b0;
    tick(2);
    resetn_in <= 1'b1;
    bus(1, 4'h0, 32'h0000_0002);
    tick(12);
    chk(32'(drive_enable_out), 32'h0);
    bus(1, 4'h8, 32'h0000_0001);
    tick(3);
    chk(32'(drive_enable_out), 32'h1);
    u_ctl.send(2, 1);
    chk(32'(drive_enable_out), 32'h0);
    u_ctl.send(1, 3);
    chk(32'(drive_enable_out), 32'h1);
    $display("t_hold done");
  endtask
  task automatic t_bits;
    bus(1, 4'h0, 32'h0000_000d);
    position_in  <= 32'h0123_4567;
    enc_index_in <= 1'b1;
    tick(3);
    chk(tx_position_out, 32'h2468_ace0);
    chk(32'(tx_home_out), 32'h1);
    chk(32'(loop_sync_req_out), 32'h1);
    bus(0, 4'h0, 32'h0);
    chk(q, 32'h0000_000d);
    bus(1, 4'h0, 32'h0000_0000);
    tick(3);
    chk(tx_position_out, 32'h0123_4567);
    chk(32'(tx_home_out), 32'h0);
    chk(32'(loop_sync_req_out), 32'h0);
    bus(0, 4'h4, 32'h0);
    chk(q, 32'h0000_0001);
    $display("t_bits done");
  endtask
  task automatic t_aux;
    logic [31:0] x;
    for (int c = 0; c < 16; c++) begin
      bus(1, 4'h0, {24'h0, c[3:0], 4'h0});
      tick(3);
      x = c == 0 ? aux_src_in.digital_in : c == 3 ? aux_src_in.motor_enc :
          c == 4 ? aux_src_in.load_enc : 32'h0;
      chk(tx_aux1_out, x);
    end
    $display("t_aux done");
  endtask
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #50us;
    n_mismatch++;
    summarize();
  end
  initial begin
    tick(10);
    resetn_in <= 1'b1;
    t_start();
    t_hold();
    t_bits();
    t_aux();
    summarize();
  end
endmodule // test_ring_network_option_bits
`default_nettype wire
